// ===== design/motor_ctl_pkg.sv
// Constants, register map and types for the motor run/stop and speed-select block
package motor_ctl_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_ADDR   = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] ENTRY_BASE  = 8'h10;
    localparam logic [7:0] ENTRY_LAST  = 8'h1C;
    localparam int         ADDR_W      = 8;

    // Control register fields
    localparam int MODE_LSB = 0;
    localparam int LOCK_BIT = 2;
    localparam int FN0_LSB  = 3;
    localparam int FN_W     = 2;
    localparam int CTRL_W   = 9;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h120;

    // Stored entry layout: speed, acceleration time, deceleration time
    localparam int SPEED_W   = 16;
    localparam int TIME_W    = 8;
    localparam int ACCEL_LSB = 16;
    localparam int DECEL_LSB = 24;
    localparam int N_ENTRY   = 4;
    localparam logic [31:0] ENTRY_RESET = 32'h0505_0000;
    localparam logic [SPEED_W-1:0] DIAL_STEP = 16'h000A;
    localparam logic [SPEED_W-1:0] SPEED_MAX = 16'hFFFF;

    // Status register fields
    localparam int ST_RUN_BIT    = 0;
    localparam int ST_CW_BIT     = 1;
    localparam int ST_ALARM_BIT  = 2;
    localparam int ST_PEND_BIT   = 3;
    localparam int ST_ENTRY_LSB  = 4;
    localparam int ST_REJECT_BIT = 6;
    localparam int ST_PSPD_LSB   = 16;

    // Rejection indication hold time
    localparam longint CLK_KHZ        = 200000;
    localparam longint REJECT_HOLD_MS = 2000;
    localparam int REJECT_HOLD_CYC = int'(REJECT_HOLD_MS * CLK_KHZ);
    localparam int HOLD_W          = 29;

    typedef enum logic [1:0] {
        EXT_OFF  = 2'h0,
        EXT_ON   = 2'h1,
        EXT_ONLY = 2'h2
    } ext_mode_e;

    typedef enum logic [1:0] {
        FN_FWD    = 2'h0,
        FN_REV    = 2'h1,
        FN_SEL_LO = 2'h2,
        FN_SEL_HI = 2'h3
    } in_fn_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_TURN
    } motor_state_e;

endpackage : motor_ctl_pkg

// ===== design/motor_run_stop_speed_select.sv
// Run/stop, direction and stored-speed selection with an AHB-Lite register slave
// Behaviour
// - Operate switch on at power-up raises alarm and blocks running.
// - Panel mode: operate position starts motor at the set speed.
// - Dial speed stays pending until pressed, then stored as entry zero.
// - Direction switch changes are accepted while running.
// - Lock makes the dial ignored so stored speed cannot change.
// - Mode OFF panel only, ON external plus panel, third external only.
// - External-only mode disables operate switch, direction switch and dial.
// - ON mode runs only with run input and operate switch; halt stops.
// - ON mode: dial changes speed, direction switch reverses rotation.
// - External-only: panel touch shows rejection, switch continuous, else two seconds.
// - External control runs when exactly one run input is asserted.
// - Releasing the run input decelerates with the active deceleration time.
// - Both run inputs asserted stop the motor instantaneously.
// - Two select inputs pick entries 0 to 3, low bit weight one.
// - Run with the selected entry; select changes move to new speed.
// - Speed changes use the newly selected entry's ramp times.
// - Forward input clockwise at forward switch; reverse switch swaps directions.
// - Direction change in external operation: decelerate to stop, then restart.
// - External-only ignores direction switch, acts as forward position.
// - Three inputs default forward, backward, low select; assignments are settable.
// - Fault output active with no alarm, inactive once any alarm exists.
`timescale 1ns/1ps
`default_nettype none
module motor_run_stop_speed_select
    import motor_ctl_pkg::*;
#(
    parameter int REJECT_HOLD = REJECT_HOLD_CYC
) (
    input  wire logic               mclk,
    input  wire logic               rst_n,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic [31:0]             hrdata,
    output logic                    hresp,
    input  wire logic               run_switch,
    input  wire logic               dir_switch_rev,
    input  wire logic               dial_up,
    input  wire logic               dial_down,
    input  wire logic               dial_press,
    input  wire logic               ctl_in0,
    input  wire logic               ctl_in1,
    input  wire logic               ctl_in2,
    input  wire logic               motor_at_rest,
    output logic                    run_cmd,
    output logic                    dir_cw,
    output logic                    quick_stop,
    output logic [SPEED_W-1:0]      speed_cmd,
    output logic [TIME_W-1:0]       accel_time,
    output logic [TIME_W-1:0]       decel_time,
    output logic [1:0]              active_entry,
    output logic                    dial_pending,
    output logic                    reject_show,
    output logic                    fault_output
);

    logic [CTRL_W-1:0]  ctrl;
    logic [31:0]        entry [N_ENTRY];
    logic [SPEED_W-1:0] pend_speed;
    logic               alarm;
    logic               boot;
    logic               dir_prev;
    logic [HOLD_W-1:0]  hold_cnt;
    motor_state_e       state;
    motor_state_e       next_state;

    logic               wr_pend;
    logic [ADDR_W-1:0]  wr_addr;
    logic [31:0]        rd_mux;
    logic               acc;
    logic               entry_wr;
    logic               entry0_wr;

    ext_mode_e          mode;
    logic               lock;
    logic               ext;
    logic               dial_ok;
    logic               forward_run_input;
    logic               backward_run_input;
    logic               sel_lo;
    logic               sel_hi;
    logic [1:0]         sel;
    logic               want_run;
    logic               want_cw;
    logic               quick;
    logic               panel_touch;
    logic [2:0]         ins;

    assign mode = ext_mode_e'(ctrl[MODE_LSB +: 2]);
    assign lock = ctrl[LOCK_BIT];
    assign ins  = {ctl_in2, ctl_in1, ctl_in0};

    // Input function decode; mode code 3 is treated as panel control
    always_comb begin
        forward_run_input    = 1'b0;
        backward_run_input    = 1'b0;
        sel_lo = 1'b0;
        sel_hi = 1'b0;
        for (int i = 0; i < 3; i++) begin
            unique case (in_fn_e'(ctrl[FN0_LSB + i*FN_W +: FN_W]))
                FN_FWD:    forward_run_input    = forward_run_input | ins[i];
                FN_REV:    backward_run_input    = backward_run_input | ins[i];
                FN_SEL_LO: sel_lo = sel_lo | ins[i];
                FN_SEL_HI: sel_hi = sel_hi | ins[i];
            endcase
        end
    end

    always_comb begin
        ext     = (mode == EXT_ON) || (mode == EXT_ONLY);
        dial_ok = !lock && (mode != EXT_ONLY);
        quick   = ext && forward_run_input && backward_run_input;
        sel     = ext ? {sel_hi, sel_lo} : 2'h0;
        if (mode == EXT_ONLY) begin
            want_run = forward_run_input ^ backward_run_input;
            want_cw  = forward_run_input && !backward_run_input;
        end else if (mode == EXT_ON) begin
            want_run = run_switch && (forward_run_input ^ backward_run_input);
            want_cw  = (forward_run_input && !backward_run_input) ^ dir_switch_rev;
        end else begin
            want_run = run_switch;
            want_cw  = !dir_switch_rev;
        end
        panel_touch = dial_up || dial_down || dial_press || (dir_switch_rev != dir_prev);
    end

    // Power-on check: only the first cycle after reset looks at the switch
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            boot  <= 1'b1;
            alarm <= 1'b0;
        end else begin
            boot <= 1'b0;
            if (boot && run_switch) begin
                alarm <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fault_output <= 1'b0;
        end else begin
            fault_output <= !alarm && !(boot && run_switch);
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (want_run && !quick && !alarm && !boot) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (quick || !want_run) begin
                    next_state = ST_IDLE;
                end else if (ext && want_cw != dir_cw) begin
                    next_state = ST_TURN;
                end
            end
            ST_TURN: begin
                // Output stays off until the drive reports standstill
                if (quick || motor_at_rest) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state      <= ST_IDLE;
            run_cmd    <= 1'b0;
            quick_stop <= 1'b0;
        end else begin
            state      <= next_state;
            run_cmd    <= (next_state == ST_RUN);
            quick_stop <= quick;
        end
    end

    // Panel mode follows the switch at once; external modes reverse via standstill
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dir_cw <= 1'b1;
        end else if (next_state == ST_RUN && (state == ST_IDLE || !ext)) begin
            dir_cw <= want_cw;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            active_entry <= 2'h0;
            speed_cmd    <= ENTRY_RESET[SPEED_W-1:0];
            accel_time   <= ENTRY_RESET[ACCEL_LSB +: TIME_W];
            decel_time   <= ENTRY_RESET[DECEL_LSB +: TIME_W];
        end else begin
            active_entry <= sel;
            speed_cmd    <= entry[sel][SPEED_W-1:0];
            accel_time   <= entry[sel][ACCEL_LSB +: TIME_W];
            decel_time   <= entry[sel][DECEL_LSB +: TIME_W];
        end
    end

    // Dial: pending copy tracks entry zero until turned, commit on press
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pend_speed   <= ENTRY_RESET[SPEED_W-1:0];
            dial_pending <= 1'b0;
        end else if (dial_ok) begin
            if (dial_press) begin
                dial_pending <= 1'b0;
            end else if (dial_up) begin
                dial_pending <= 1'b1;
                pend_speed   <= (pend_speed > SPEED_MAX - DIAL_STEP) ? SPEED_MAX
                                                                     : pend_speed + DIAL_STEP;
            end else if (dial_down) begin
                dial_pending <= 1'b1;
                pend_speed   <= (pend_speed < DIAL_STEP) ? '0 : pend_speed - DIAL_STEP;
            end else if (!dial_pending) begin
                pend_speed <= entry[0][SPEED_W-1:0];
            end
        end
    end

    assign entry_wr  = wr_pend && wr_addr >= ENTRY_BASE && wr_addr <= ENTRY_LAST;
    assign entry0_wr = entry_wr && (wr_addr[3:2] == 2'h0);

    // A bus write to entry zero in the same cycle as a dial commit wins.
    // A write to any other entry must not swallow the commit: the pending
    // flag clears on the press either way, so the dialled speed would be lost.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            for (int i = 0; i < N_ENTRY; i++) begin
                entry[i] <= ENTRY_RESET;
            end
        end else begin
            if (dial_ok && dial_press && dial_pending && !entry0_wr) begin
                entry[0][SPEED_W-1:0] <= pend_speed;
            end
            if (entry_wr) begin
                entry[wr_addr[3:2]] <= hwdata;
            end
        end
    end

    // Rejection indication for panel use while external-only
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dir_prev <= 1'b0;
            hold_cnt <= '0;
        end else begin
            dir_prev <= dir_switch_rev;
            if (mode == EXT_ONLY && panel_touch) begin
                hold_cnt <= HOLD_W'(REJECT_HOLD);
            end else if (hold_cnt != '0) begin
                hold_cnt <= hold_cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reject_show <= 1'b0;
        end else begin
            reject_show <= (mode == EXT_ONLY) && (run_switch || hold_cnt != '0);
        end
    end

    // AHB-Lite slave: zero wait states, always OKAY, unmapped reads zero
    assign acc = hsel && hready && htrans[1];

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (haddr[ADDR_W-1:0] == CTRL_ADDR) begin
            rd_mux[CTRL_W-1:0] = ctrl;
        end else if (haddr[ADDR_W-1:0] == STATUS_ADDR) begin
            rd_mux[ST_RUN_BIT]                   = run_cmd;
            rd_mux[ST_CW_BIT]                    = dir_cw;
            rd_mux[ST_ALARM_BIT]                 = alarm;
            rd_mux[ST_PEND_BIT]                  = dial_pending;
            rd_mux[ST_ENTRY_LSB +: 2]            = active_entry;
            rd_mux[ST_REJECT_BIT]                = reject_show;
            rd_mux[ST_PSPD_LSB +: SPEED_W]       = pend_speed;
        end else if (haddr[ADDR_W-1:0] >= ENTRY_BASE && haddr[ADDR_W-1:0] <= ENTRY_LAST
                     && haddr[1:0] == 2'h0) begin
            rd_mux = entry[haddr[3:2]];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wr_pend   <= 1'b0;
            wr_addr   <= '0;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend   <= acc && hwrite;
            wr_addr   <= haddr[ADDR_W-1:0];
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (acc && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
        end else if (wr_pend && wr_addr == CTRL_ADDR) begin
            ctrl <= hwdata[CTRL_W-1:0];
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence ext_turn_s;
        state == ST_RUN && next_state == ST_TURN;
    endsequence

    sequence stop_then_idle_s;
        !run_cmd [*1] ##0 (state == ST_TURN || state == ST_IDLE);
    endsequence

    alarm_block_a: assert property (alarm |-> !run_cmd && !(state == ST_RUN))
        else $error("motor runs under power-on alarm");
    fault_follow_a: assert property (alarm |=> !fault_output)
        else $error("fault output active with alarm raised");
    panel_start_a: assert property (mode == EXT_OFF && state == ST_IDLE && run_switch
        && !alarm && !boot |=> run_cmd && speed_cmd == $past(entry[0][SPEED_W-1:0]))
        else $error("panel start missing");
    dial_commit_a: assert property (dial_ok && dial_press && dial_pending && !wr_pend
        |=> entry[0][SPEED_W-1:0] == $past(pend_speed) && !dial_pending)
        else $error("dial commit not stored");
    lock_hold_a: assert property (!dial_ok && !wr_pend |=> $stable(entry[0]))
        else $error("entry zero changed while dial disabled");
    halt_stop_a: assert property (mode == EXT_ON && !run_switch |=> !run_cmd)
        else $error("ON mode runs with switch at halt");
    both_stop_a: assert property (quick |=> quick_stop && !run_cmd)
        else $error("no instant stop on both inputs");
    // Speed and ramp registers load from the entry as it stood one edge earlier
    select_map_a: assert property (ext |=> active_entry == $past({sel_hi, sel_lo})
        && speed_cmd == $past(entry[sel][SPEED_W-1:0]))
        else $error("speed select decode wrong");
    ramp_new_a: assert property (ext ##1 $changed(active_entry)
        |-> accel_time == $past(entry[sel][ACCEL_LSB +: TIME_W])
        && decel_time == $past(entry[sel][DECEL_LSB +: TIME_W]))
        else $error("ramp times not from new entry");
    reject_run_a: assert property (mode == EXT_ONLY && run_switch |=> reject_show)
        else $error("rejection not shown for operate switch");
    reject_hold_a: assert property (mode == EXT_ONLY && panel_touch
        |=> hold_cnt == HOLD_W'(REJECT_HOLD))
        else $error("rejection hold not loaded");
    ext_turn_a: assert property (ext_turn_s |=> stop_then_idle_s)
        else $error("direction change did not stop first");
    only_dir_a: assert property (mode == EXT_ONLY && state == ST_IDLE && next_state == ST_RUN
        |=> dir_cw == $past(forward_run_input))
        else $error("external-only direction wrong");
    one_input_a: assert property (ext && state == ST_IDLE && (forward_run_input ^ backward_run_input) && !alarm && !boot
        && (mode == EXT_ONLY || run_switch) |=> run_cmd)
        else $error("single run input did not start");

endmodule : motor_run_stop_speed_select
`default_nettype wire

// ===== test/ctl_partner.sv
// Stand-in for the controller lines and for the drive's at-rest report
`timescale 1ns/1ps
`default_nettype none
module ctl_partner #(
    parameter int STOP_CYC = 7
) (
    input  wire logic       mclk,
    input  wire logic       fwd_req,
    input  wire logic       rev_req,
    input  wire logic [1:0] sel_req,
    input  wire logic [5:0] fn_map,
    input  wire logic       run_cmd,
    output logic [2:0]      ctl_in,
    output logic            motor_at_rest
);
    logic [2:0] lines    = 3'h0;
    logic [7:0] idle_cnt = 8'h00;

    function automatic logic pick(input logic [1:0] f);
        case (f)
            2'h0:    pick = fwd_req;
            2'h1:    pick = rev_req;
            2'h2:    pick = sel_req[0];
            default: pick = sel_req[1];
        endcase
    endfunction

    // Each line carries the function the block was told it carries
    always_ff @(posedge mclk) begin
        for (int i = 0; i < 3; i++) begin
            lines[i] <= pick(fn_map[2*i +: 2]);
        end
    end
    assign ctl_in = lines;

    // The drive coasts for several cycles, so a restart must wait for rest
    always_ff @(posedge mclk) begin
        if (run_cmd)
            idle_cnt <= 8'h00;
        else if (idle_cnt < 8'(STOP_CYC))
            idle_cnt <= idle_cnt + 8'h01;
    end
    assign motor_at_rest = (idle_cnt >= 8'(STOP_CYC));
endmodule : ctl_partner
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for the motor run/stop and speed-select block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import motor_ctl_pkg::*;
    localparam int HOLD  = 20;
    localparam int STOP  = 7;
    localparam int LIMIT = 4000;
    logic mclk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat, ev;
    logic [1:0] htrans = 2'h0, sel = 2'h0, active_entry;
    logic [2:0] hsize = 3'h2, dialv = 3'h0, ctl_in;
    logic [5:0] fn_map = 6'h24;
    logic run_switch = 1'b0, dir_switch_rev = 1'b0, forward_run_input = 1'b0, backward_run_input = 1'b0;
    logic dial_up, dial_down, dial_press, motor_at_rest, hreadyout, hresp;
    logic run_cmd, dir_cw, quick_stop, dial_pending, reject_show, fault_output;
    logic [SPEED_W-1:0] speed_cmd;
    logic [TIME_W-1:0] accel_time, decel_time;
    int num_errors = 0, n_checks = 0, cyc = 0, n;

    always #2.5 mclk = ~mclk;
    assign hready = hreadyout;
    assign {dial_press, dial_down, dial_up} = dialv;

    motor_run_stop_speed_select #(.REJECT_HOLD(HOLD)) motor_run_stop_speed_select_inst (
        .mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hrdata, .hresp, .run_switch, .dir_switch_rev, .dial_up,
        .dial_down, .dial_press, .ctl_in0(ctl_in[0]), .ctl_in1(ctl_in[1]),
        .ctl_in2(ctl_in[2]), .motor_at_rest, .run_cmd, .dir_cw, .quick_stop,
        .speed_cmd, .accel_time, .decel_time, .active_entry, .dial_pending,
        .reject_show, .fault_output
    );
    ctl_partner #(.STOP_CYC(STOP)) ctl_partner_inst (
        .mclk, .fwd_req(forward_run_input), .rev_req(backward_run_input), .sel_req(sel), .fn_map, .run_cmd,
        .ctl_in, .motor_at_rest
    );

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic chk_bit(input string what, input logic e, input logic g);
        chk(what, {31'h0, e}, {31'h0, g});
    endtask : chk_bit

    task automatic look(input int c);
        repeat (c) @(posedge mclk);
        @(negedge mclk);
    endtask : look

    // Address phase held until hready, then data phase held until hready
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        r = hrdata;
        chk_bit("hresp", 1'b0, hresp);
    endtask : ahb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d, rdat);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        ahb(1'b0, a, 32'h0, rdat);
        chk($sformatf("reg %h", a), e, rdat & m);
    endtask : rdc
    task automatic set_ctrl(input logic [31:0] v);
        wr(CTRL_ADDR, v);
        fn_map <= v[8:3];
    endtask : set_ctrl

    task automatic do_reset(input logic rs);
        @(posedge mclk);
        rst_n <= 1'b0;
        run_switch <= rs;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        look(3);
    endtask : do_reset
    task automatic set_sw(input logic r, input logic d);
        @(posedge mclk);
        run_switch <= r;
        dir_switch_rev <= d;
        look(2);
    endtask : set_sw
    task automatic dial(input int k);
        @(posedge mclk);
        dialv <= 3'h1 << k;
        @(posedge mclk);
        dialv <= 3'h0;
        look(1);
    endtask : dial
    // Controller keeps every level long enough to be seen
    task automatic ext(input logic f, input logic r, input logic [1:0] s);
        @(posedge mclk);
        forward_run_input <= f;
        backward_run_input <= r;
        sel <= s;
        look(6);
    endtask : ext

    initial begin
        do_reset(1'b1);
        chk_bit("fault_output", 1'b0, fault_output);
        chk_bit("run_cmd", 1'b0, run_cmd);
        rdc(STATUS_ADDR, 32'h4, 32'h4);
        do_reset(1'b0);
        chk_bit("fault_output", 1'b1, fault_output);
        rdc(CTRL_ADDR, '1, 32'h120);
        for (int i = 0; i < N_ENTRY; i++)
            rdc(ENTRY_BASE + 8'(4 * i), '1, 32'h0505_0000);
        wr(8'h08, '1);
        rdc(8'h08, '1, 32'h0);
        wr(STATUS_ADDR, '1);
        rdc(STATUS_ADDR, 32'h7F, 32'h2);
        wr(ENTRY_BASE, 32'h0A0B_03E8);
        set_sw(1'b1, 1'b0);
        chk_bit("run_cmd", 1'b1, run_cmd);
        chk("speed_cmd", 32'h3E8, 32'(speed_cmd));
        set_sw(1'b1, 1'b1);
        chk_bit("run_cmd", 1'b1, run_cmd);
        chk_bit("dir_cw", 1'b0, dir_cw);
        set_sw(1'b1, 1'b0);
        dial(0);
        dial(0);
        dial(1);
        chk_bit("dial_pending", 1'b1, dial_pending);
        chk("speed_cmd", 32'h3E8, 32'(speed_cmd));
        rdc(STATUS_ADDR, 32'hFFFF_0008, 32'h03F2_0008);
        dial(2);
        chk("speed_cmd", 32'h3F2, 32'(speed_cmd));
        rdc(ENTRY_BASE, 32'hFFFF, 32'h3F2);
        set_ctrl(32'h124);
        dial(0);
        dial(2);
        chk_bit("dial_pending", 1'b0, dial_pending);
        chk("speed_cmd", 32'h3F2, 32'(speed_cmd));
        set_sw(1'b0, 1'b0);
        set_ctrl(32'h121);
        set_sw(1'b1, 1'b0);
        chk_bit("run_cmd", 1'b0, run_cmd);
        ext(1'b1, 1'b0, 2'h0);
        chk_bit("run_cmd", 1'b1, run_cmd);
        chk_bit("dir_cw", 1'b1, dir_cw);
        dial(0);
        dial(2);
        chk("speed_cmd", 32'h3FC, 32'(speed_cmd));
        ext(1'b0, 1'b0, 2'h0);
        chk_bit("run_cmd", 1'b0, run_cmd);
        chk("decel_time", 32'h0A, 32'(decel_time));
        ext(1'b0, 1'b1, 2'h0);
        chk_bit("run_cmd", 1'b1, run_cmd);
        chk_bit("dir_cw", 1'b0, dir_cw);
        ext(1'b1, 1'b1, 2'h0);
        chk_bit("quick_stop", 1'b1, quick_stop);
        chk_bit("run_cmd", 1'b0, run_cmd);
        ext(1'b1, 1'b0, 2'h0);
        set_sw(1'b0, 1'b0);
        chk_bit("run_cmd", 1'b0, run_cmd);
        set_sw(1'b1, 1'b0);
        chk_bit("run_cmd", 1'b1, run_cmd);
        set_sw(1'b1, 1'b1);
        chk_bit("run_cmd", 1'b0, run_cmd);
        n = 0;
        while (run_cmd !== 1'b1 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        chk_bit("restart delay", 1'b1, n >= STOP - 2);
        chk_bit("dir_cw", 1'b0, dir_cw);
        ext(1'b0, 1'b0, 2'h0);
        ext(1'b0, 1'b1, 2'h0);
        chk_bit("dir_cw", 1'b1, dir_cw);
        ext(1'b0, 1'b0, 2'h0);
        set_sw(1'b1, 1'b0);
        set_ctrl(32'h161);
        for (int i = 0; i < N_ENTRY; i++) begin
            ev = 32'h2030_1000 + 32'h0101_1000 * 32'(i);
            wr(ENTRY_BASE + 8'(4 * i), ev);
            ext(1'b1, 1'b0, 2'(i));
            chk("active_entry", 32'(i), 32'(active_entry));
            chk("speed_cmd", 32'(ev[15:0]), 32'(speed_cmd));
            chk("accel_time", 32'(ev[23:16]), 32'(accel_time));
            chk("decel_time", 32'(ev[31:24]), 32'(decel_time));
        end
        ext(1'b0, 1'b0, 2'h0);
        set_ctrl(32'h122);
        set_sw(1'b0, 1'b0);
        ext(1'b1, 1'b0, 2'h0);
        chk_bit("run_cmd", 1'b1, run_cmd);
        set_sw(1'b0, 1'b1);
        look(11);
        chk_bit("reject_show", 1'b1, reject_show);
        chk_bit("dir_cw", 1'b1, dir_cw);
        chk_bit("run_cmd", 1'b1, run_cmd);
        look(12);
        chk_bit("reject_show", 1'b0, reject_show);
        set_sw(1'b1, 1'b1);
        look(30);
        chk_bit("reject_show", 1'b1, reject_show);
        set_sw(1'b0, 1'b1);
        chk_bit("reject_show", 1'b0, reject_show);
        dial(0);
        chk_bit("dial_pending", 1'b0, dial_pending);
        chk_bit("reject_show", 1'b1, reject_show);
        wr(ENTRY_BASE + 8'h4, 32'h0707_0123);
        rdc(ENTRY_BASE + 8'h4, '1, 32'h0707_0123);
        ext(1'b0, 1'b0, 2'h0);
        chk_bit("run_cmd", 1'b0, run_cmd);
        set_ctrl(32'h123);
        set_sw(1'b1, 1'b0);
        chk_bit("run_cmd", 1'b1, run_cmd);
        chk_bit("reject_show", 1'b0, reject_show);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
